// file: cond_eval.sv
`timescale 1ns/100ps
module cond_eval
  import lbranch_pkg::*;
(
  input  wire logic [7:0] opcode,
  input  wire logic       flag_n,
  input  wire logic       flag_z,
  input  wire logic       flag_v,
  input  wire logic       flag_c,
  output logic            take
);
  logic nxv;
  assign nxv = flag_n ^ flag_v;
  always_comb
  begin
    unique case (opcode)
      branch_long_always:               take = 1'b1;
      branch_long_never:                take = 1'b0;
      branch_long_unsigned_higher:      take = ~(flag_c | flag_z);
      branch_long_unsigned_lower_same:  take = flag_c | flag_z;
      branch_long_carry_clear:          take = ~flag_c;
      branch_long_carry_set:            take = flag_c;
      branch_long_not_equal:            take = ~flag_z;
      branch_long_equal:                take = flag_z;
      branch_long_overflow_clear:       take = ~flag_v;
      branch_long_overflow_set:         take = flag_v;
      branch_long_plus:                 take = ~flag_n;
      branch_long_minus:                take = flag_n;
      branch_long_signed_greater_equal: take = ~nxv;
      branch_long_signed_less:          take = nxv;
      branch_long_signed_greater:       take = ~(flag_z | nxv);
      branch_long_signed_less_equal:    take = flag_z | nxv;
      default:                          take = 1'b0;
    endcase
  end
endmodule : cond_eval

// file: fetch_model.sv
`timescale 1ns/100ps
module fetch_model
(
  input  wire logic        mclk,
  input  wire logic        insn_ready,
  input  wire logic        req,
  input  wire logic [31:0] req_word,
  output logic             insn_valid,
  output logic [31:0]      word,
  output logic             accepted
);
  initial
  begin
    insn_valid = 1'b0;
    word = 32'h0000_0000;
    accepted = 1'b0;
  end
  // Bytes hold until ready is seen high; once released they turn to their inverse so stale bytes never look valid.
  always @(posedge mclk)
  begin
    accepted <= insn_valid & insn_ready;
    if (req)
    begin
      insn_valid <= 1'b1;
      word <= req_word;
    end
    else if (insn_valid & insn_ready)
    begin
      insn_valid <= 1'b0;
      word <= ~word;
    end
  end
endmodule : fetch_model

// file: lbranch_pkg.sv
// Overview of operation
// - A taken conditional long branch costs four cycles because the queue refills, a not-taken one three.
// - The overflow-set branch loads the program counter with itself plus 0004 plus the offset when overflow is one.
// - Overflow-set uses 18 29 and overflow-clear uses 18 28.
// - Signed greater (18 2E) branches when Z or (N xor V) is 0, signed less-equal (18 2F) when it is 1.
// - Signed greater-equal (18 2C) branches when N xor V is 0, signed less (18 2D) when it is 1.
// - Unsigned higher (18 22) branches when C or Z is 0, lower-same (18 23) when it is 1.
// - Higher-same/carry-clear (18 24) branches when C is 0, lower/carry-set (18 25) when C is 1.
// - Equal (18 27) branches when Z is 1, not-equal (18 26) when Z is 0.
// - Minus (18 2B) branches when N is 1, plus (18 2A) when N is 0.
// - Overflow-set is taken after a two's complement operation whose signed result overflowed.
// - The offset is a 16-bit two's complement value from the third and fourth instruction bytes.
package lbranch_pkg;
  localparam logic [7:0]  PREFIX_BYTE   = 8'h18;
  localparam logic [15:0] PC_STEP       = 16'h0004;
  localparam logic [2:0]  CYCLES_TAKEN  = 3'h4;
  localparam logic [2:0]  CYCLES_FALL   = 3'h3;
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [7:0]  branch_long_always               = 8'h20;
  localparam logic [7:0]  branch_long_never                = 8'h21;
  localparam logic [7:0]  branch_long_unsigned_higher      = 8'h22;
  localparam logic [7:0]  branch_long_unsigned_lower_same  = 8'h23;
  localparam logic [7:0]  branch_long_unsigned_higher_same = 8'h24;
  localparam logic [7:0]  branch_long_carry_clear          = 8'h24;
  localparam logic [7:0]  branch_long_unsigned_lower       = 8'h25;
  localparam logic [7:0]  branch_long_carry_set            = 8'h25;
  localparam logic [7:0]  branch_long_not_equal            = 8'h26;
  localparam logic [7:0]  branch_long_equal                = 8'h27;
  localparam logic [7:0]  branch_long_overflow_clear       = 8'h28;
  localparam logic [7:0]  branch_long_overflow_set         = 8'h29;
  localparam logic [7:0]  branch_long_plus                 = 8'h2a;
  localparam logic [7:0]  branch_long_minus                = 8'h2b;
  localparam logic [7:0]  branch_long_signed_greater_equal = 8'h2c;
  localparam logic [7:0]  branch_long_signed_less          = 8'h2d;
  localparam logic [7:0]  branch_long_signed_greater       = 8'h2e;
  localparam logic [7:0]  branch_long_signed_less_equal    = 8'h2f;
  localparam logic [7:0]  OP_FIRST = 8'h20;
  localparam logic [7:0]  OP_LAST  = 8'h2f;
endpackage : lbranch_pkg

// file: long_branch_condition_unit.sv
`timescale 1ns/100ps
module long_branch_condition_unit
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       insn_valid,
  input  wire logic [7:0] insn_byte0,
  input  wire logic [7:0] insn_byte1,
  input  wire logic [7:0] insn_byte2,
  input  wire logic [7:0] insn_byte3,
  input  wire logic [15:0] pc_in,
  input  wire logic       flag_n,
  input  wire logic       flag_z,
  input  wire logic       flag_v,
  input  wire logic       flag_c,
  output logic            insn_ready,
  output logic            busy,
  output logic            done,
  output logic            taken,
  output logic            queue_refill,
  output logic            illegal,
  output logic [15:0]     pc_out,
  output logic [2:0]      cycle_count
);
  import lbranch_pkg::*;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } state_t;

  typedef struct packed
  {
    state_t      state;
    logic [2:0]  left;
    logic [2:0]  cycles;
    logic        taken;
    logic        done;
    logic        illegal;
    logic        refill;
    logic        ready;
    logic        busy;
    logic [15:0] pc;
  } regs_t;

  regs_t q;
  regs_t d;
  logic  take;
  logic  is_long;
  logic [15:0] offset;
  logic [15:0] fall_pc;

  cond_eval u_eval
  (
    .opcode (insn_byte1),
    .flag_n (flag_n),
    .flag_z (flag_z),
    .flag_v (flag_v),
    .flag_c (flag_c),
    .take   (take)
  );

  // The offset sits in the third and fourth bytes, high byte first.
  assign offset  = {insn_byte2, insn_byte3};
  assign fall_pc = pc_in + PC_STEP;
  assign is_long = (insn_byte0 == PREFIX_BYTE) && (insn_byte1 >= OP_FIRST)
                   && (insn_byte1 <= OP_LAST);

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.illegal = 1'b0;
    unique case (q.state)
      ST_IDLE:
      begin
        if (insn_valid && q.ready)
        begin
          if (is_long)
          begin
            d.state  = ST_EXEC;
            d.ready  = 1'b0;
            d.busy   = 1'b1;
            d.taken  = take;
            d.refill = take;
            // Wraps modulo 64 KiB like the program counter itself.
            d.pc     = take ? fall_pc + offset : fall_pc;
            d.cycles = take ? CYCLES_TAKEN : CYCLES_FALL;
            d.left   = take ? CYCLES_TAKEN - 3'h1 : CYCLES_FALL - 3'h1;
          end
          else
          begin
            d.illegal = 1'b1;
          end
        end
      end
      ST_EXEC:
      begin
        if (q.left == 3'h1)
        begin
          d.state  = ST_IDLE;
          d.done   = 1'b1;
          d.ready  = 1'b1;
          d.busy   = 1'b0;
          d.refill = 1'b0;
          d.left   = 3'h0;
        end
        else
        begin
          d.left = q.left - 3'h1;
        end
      end
      default:
      begin
        d.state = ST_IDLE;
        d.ready = 1'b1;
        d.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '{state: ST_IDLE, left: 3'h0, cycles: 3'h0, taken: 1'b0, done: 1'b0,
             illegal: 1'b0, refill: 1'b0, ready: 1'b1, busy: 1'b0, pc: PC_RESET};
    end
    else
    begin
      q <= d;
    end
  end

  // No flag output exists, so the condition codes cannot be disturbed.
  assign insn_ready   = q.ready;
  assign busy         = q.busy;
  assign done         = q.done;
  assign taken        = q.taken;
  assign queue_refill = q.refill;
  assign illegal      = q.illegal;
  assign pc_out       = q.pc;
  assign cycle_count  = q.cycles;

  // Flags are sampled in the accepting cycle, so each decision check looks back one edge.
  cycles_taken_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && is_long && take) |=> busy [*3] ##1 done)
    else $error("taken branch did not finish in four cycles");
  cycles_fall_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && is_long && !take) |=> busy [*2] ##1 done)
    else $error("untaken branch did not finish in three cycles");
  cost_taken_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && is_long && take) |=> cycle_count == 3'h4)
    else $error("taken branch reports the wrong cost");
  cost_fall_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && is_long && !take) |=> cycle_count == 3'h3)
    else $error("untaken branch reports the wrong cost");
  target_pc_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && is_long && take)
      |=> pc_out == $past(pc_in) + 16'h0004 + $past({insn_byte2, insn_byte3}))
    else $error("taken target is wrong");
  fall_pc_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && is_long && !take) |=> pc_out == $past(pc_in) + 16'h0004)
    else $error("fall-through address is wrong");
  overflow_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h29)
      |=> taken == $past(flag_v))
    else $error("overflow-set decision wrong");
  overflow_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h28)
      |=> taken == !$past(flag_v))
    else $error("overflow-clear decision wrong");
  signed_gt_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h2e)
      |=> taken == !$past(flag_z | (flag_n ^ flag_v)))
    else $error("signed greater decision wrong");
  signed_le_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h2f)
      |=> taken == $past(flag_z | (flag_n ^ flag_v)))
    else $error("signed less-equal decision wrong");
  signed_ge_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h2c)
      |=> taken == !$past(flag_n ^ flag_v))
    else $error("signed greater-equal decision wrong");
  signed_lt_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h2d)
      |=> taken == $past(flag_n ^ flag_v))
    else $error("signed less decision wrong");
  unsigned_hi_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h22)
      |=> taken == !$past(flag_c | flag_z))
    else $error("unsigned higher decision wrong");
  unsigned_ls_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h23)
      |=> taken == $past(flag_c | flag_z))
    else $error("unsigned lower-same decision wrong");
  carry_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h24)
      |=> taken == !$past(flag_c))
    else $error("carry-clear decision wrong");
  carry_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h25)
      |=> taken == $past(flag_c))
    else $error("carry-set decision wrong");
  equal_branch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h27)
      |=> taken == $past(flag_z))
    else $error("equal decision wrong");
  not_equal_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h26)
      |=> taken == !$past(flag_z))
    else $error("not-equal decision wrong");
  minus_branch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h2b)
      |=> taken == $past(flag_n))
    else $error("minus decision wrong");
  plus_branch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h2a)
      |=> taken == !$past(flag_n))
    else $error("plus decision wrong");
  always_branch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h20)
      |=> taken && queue_refill)
    else $error("always branch was not taken");
  never_branch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && insn_byte0 == 8'h18 && insn_byte1 == 8'h21)
      |=> !taken && !queue_refill)
    else $error("never branch was taken");
  illegal_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (insn_valid && insn_ready && !is_long) |=> illegal && !busy && insn_ready)
    else $error("foreign bytes were not refused");
  pc_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (busy && $past(busy)) |-> $stable(pc_out))
    else $error("target moved during execution");
  busy_ready_a: assert property (@(posedge mclk) disable iff (!rst_b)
    busy |-> !insn_ready)
    else $error("ready raised while executing");
  done_ends_a: assert property (@(posedge mclk) disable iff (!rst_b)
    done |-> !busy && insn_ready && !queue_refill)
    else $error("done without returning to idle");
  refill_taken_a: assert property (@(posedge mclk) disable iff (!rst_b)
    done |-> $past(queue_refill) == taken)
    else $error("refill does not match decision");
endmodule : long_branch_condition_unit

// file: long_branch_condition_unit_tb.sv
`timescale 1ns/100ps
module long_branch_condition_unit_tb;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        req = 1'b0;
  logic [31:0] req_word = 32'h0000_0000;
  logic [15:0] pc_in = 16'h0000;
  logic        flag_n = 1'b0, flag_z = 1'b0, flag_v = 1'b0, flag_c = 1'b0;
  logic        insn_valid, accepted, insn_ready, busy, done, taken, queue_refill, illegal;
  logic [31:0] word;
  logic [15:0] pc_out;
  logic [2:0]  cycle_count;
  int          errors = 0;
  int          checks = 0;
  always #50 mclk = ~mclk;
  fetch_model u_fetch (.mclk(mclk), .insn_ready(insn_ready), .req(req), .req_word(req_word),
                       .insn_valid(insn_valid), .word(word), .accepted(accepted));
  long_branch_condition_unit u_dut (.mclk(mclk), .rst_b(rst_b), .insn_valid(insn_valid),
    .insn_byte0(word[31:24]), .insn_byte1(word[23:16]), .insn_byte2(word[15:8]), .insn_byte3(word[7:0]),
    .pc_in(pc_in), .flag_n(flag_n), .flag_z(flag_z), .flag_v(flag_v), .flag_c(flag_c),
    .insn_ready(insn_ready), .busy(busy), .done(done), .taken(taken), .queue_refill(queue_refill),
    .illegal(illegal), .pc_out(pc_out), .cycle_count(cycle_count));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  function automatic logic want(input logic [7:0] op, input logic [3:0] f);
    logic n, z, v, c;
    {n, z, v, c} = f;
    case (op)
      8'h20: want = 1'b1;
      8'h21: want = 1'b0;
      8'h22: want = !(c | z);
      8'h23: want = c | z;
      8'h24: want = !c;
      8'h25: want = c;
      8'h26: want = !z;
      8'h27: want = z;
      8'h28: want = !v;
      8'h29: want = v;
      8'h2a: want = !n;
      8'h2b: want = n;
      8'h2c: want = !(n ^ v);
      8'h2d: want = n ^ v;
      8'h2e: want = !(z | (n ^ v));
      default: want = z | (n ^ v);
    endcase
  endfunction : want
  // Sends one instruction and returns just after the accepting edge.
  task automatic issue(input logic [31:0] w, input logic [15:0] pc, input logic [3:0] f);
    int n;
    pc_in = pc;
    {flag_n, flag_z, flag_v, flag_c} = f;
    req_word = w;
    req = 1'b1;
    @(posedge mclk);
    #1 req = 1'b0;
    n = 0;
    while (accepted !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk(accepted, 1'b1);
  endtask : issue
  task automatic run(input logic [7:0] op, input logic [15:0] pc, input logic [15:0] off, input logic [3:0] f);
    int  m;
    logic tk;
    tk = want(op, f);
    issue({8'h18, op, off}, pc, f);
    @(posedge mclk);
    #1 chk(taken, tk);
    chk(pc_out, tk ? pc + 16'h0004 + off : pc + 16'h0004);
    chk(cycle_count, tk ? 16'h0004 : 16'h0003);
    chk(queue_refill, tk);
    chk(busy, 1'b1);
    chk(insn_ready, 1'b0);
    chk(illegal, 1'b0);
    // The accepting cycle and the one after it are already behind us here.
    m = 2;
    while (done !== 1'b1 && m < 10)
    begin
      @(posedge mclk);
      #1 m++;
    end
    chk(m[15:0], tk ? 16'h0004 : 16'h0003);
    chk(queue_refill, 1'b0);
    chk(insn_ready, 1'b1);
  endtask : run
  initial
  begin
    logic [15:0] last_pc;
    repeat (4) @(posedge mclk);
    #1 rst_b = 1'b1;
    for (int op = 0; op < 16; op++)
      for (int f = 0; f < 16; f++)
        run(8'h20 + op[7:0], {op[3:0], f[3:0], 8'hf8}, f[0] ? 16'h8000 : 16'h7ffd, f[3:0]);
    $display("test branch table done");
    last_pc = pc_out;
    issue(32'h1830_1234, 16'h0100, 4'hf);
    chk(illegal, 1'b1);
    chk(pc_out, last_pc);
    @(posedge mclk);
    #1 chk(illegal, 1'b0);
    issue(32'h1920_1234, 16'h0200, 4'h0);
    chk(illegal, 1'b1);
    chk(pc_out, last_pc);
    @(posedge mclk);
    #1 chk(illegal, 1'b0);
    $display("test illegal done");
    issue({8'h18, 8'h20, 16'h0010}, 16'h0300, 4'h0);
    rst_b = 1'b0;
    #1 chk(busy, 1'b0);
    chk(insn_ready, 1'b1);
    chk(pc_out, 16'h0000);
    chk(taken, 1'b0);
    chk(queue_refill, 1'b0);
    chk(cycle_count, 16'h0000);
    @(posedge mclk);
    #1 rst_b = 1'b1;
    run(8'h29, 16'h0400, 16'h0020, 4'h2);
    $display("test reset done");
    print_verdict();
  end
  initial
  begin
    #1000000;
    errors++;
    print_verdict();
  end
endmodule : long_branch_condition_unit_tb
